// ### hdl/bew_engine_regs.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Function
// - Setup pattern address holds bits 28:6.
// - Setup pattern address only for line drawing.
// - Pattern is 8x8 pixels, size follows depth.
// - Monochrome pattern comes with command, no fetch.
// - Setup pattern bits 5:0 read zero.
// - Destination address is working, engine updates it.
// - Destination write starts the engine, except with the setup command.
// - Line, pixel, glyph lines checked against clip.
// - Fill and copy start at destination byte.
// - Source pitch signed 16 bits, in bytes.
// - Tiled coordinate source pitch counts doublewords.
// - Copy adds source pitch after each line except the last.
// - Pitch register upper half reads debug status.
// - Source address 29 bits, low three first byte.
// - Copy reads from source address first.
// - Solid select on mono: background pattern operand.
// - Solid select clear: normal pattern operand.
// - Solid select ignored for colour patterns.
// - Raster operation code in bits 23:16.
// - Bit 30 enables clipping.
module bew_engine_regs
	import bew_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [31:0] rdData,
	input wire logic patAck,
	input wire logic lineAck,
	output logic patReq,
	output bew_pat_t patCmd,
	output logic lineReq,
	output bew_line_t lineCmd,
	output logic patUseBg,
	output logic [7:0] ropCode,
	output logic busy
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [28:0] pitchStep(input logic [15:0] p, input logic dw);
		pitchStep = dw ? {{11{p[15]}}, p, 2'b00} : {{13{p[15]}}, p};
	endfunction

	function automatic logic [8:0] patBytes(input logic [1:0] depth);
		case (depth)
			2'b00: patBytes = PAT_BYTES_8;
			2'b11: patBytes = PAT_BYTES_32;
			default: patBytes = PAT_BYTES_16;
		endcase
	endfunction

	typedef enum logic [2:0] {ST_IDLE, ST_PAT, ST_ISSUE, ST_LINE, ST_STEP} bew_state_t;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [ADDR_MSB:PAT_LSB] setupPat;
	logic [ADDR_MSB:PAT_LSB] patAddr;
	logic [ADDR_MSB:0] destAddr;
	logic [ADDR_MSB:0] srcAddr;
	logic [ADDR_MSB:0] clipTop;
	logic [ADDR_MSB:0] clipBot;
	logic [15:0] srcPitch;
	logic [31:0] ropCtrl;
	logic [7:0] cmdCfg;
	logic [12:0] lineCount;
	logic [12:0] remaining;
	logic lastClipped;
	bew_state_t state;
	bew_state_t next_state;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire logic [2:0] cmdType = cmdCfg[2:0];
	wire logic monoPat = cmdCfg[CMD_MONO_PAT_BIT];
	wire logic coordBlit = cmdCfg[CMD_COORD_BIT];
	wire logic tiledSrc = cmdCfg[CMD_TILED_SRC_BIT];
	wire logic tiledDst = cmdCfg[CMD_TILED_DST_BIT];
	wire logic solidSel = ropCtrl[ROP_SOLID_BIT];
	wire logic clipEn = ropCtrl[ROP_CLIP_BIT];
	wire logic [1:0] depth = ropCtrl[ROP_DEPTH_LSB +: 2];
	// Bus writes are locked out while the engine owns its working registers
	wire logic wrOk = wrEn && !busy;
	wire logic destHit = wrOk && (addr == OFS_DEST);
	wire logic startHit = destHit && (cmdType != CMD_SETUP);
	// Mono patterns ride in the command, pixel draws use a solid colour
	wire logic needFetch = !monoPat && (cmdType != CMD_PIXEL);
	wire logic clipCmd = (cmdType == CMD_LINE) || (cmdType == CMD_PIXEL) || (cmdType == CMD_GLYPH);
	wire logic multiLine = (cmdType == CMD_FILL) || (cmdType == CMD_COPY) || (cmdType == CMD_GLYPH);
	wire logic colourSrc = (cmdType == CMD_COPY);
	wire logic inClip = (destAddr >= clipTop) && (destAddr <= clipBot);
	wire logic lineWrite = !(clipEn && clipCmd) || inClip;
	wire logic [ADDR_MSB:0] patBase = (cmdType == CMD_LINE) ? {setupPat, 6'h00} : {patAddr, 6'h00};
	wire logic [28:0] srcStep = pitchStep(srcPitch, coordBlit && tiledSrc);
	wire logic [28:0] dstStep = pitchStep(ropCtrl[15:0], coordBlit && tiledDst);
	wire logic [12:0] startLines = (!multiLine || lineCount == RST_LINES) ? 13'h0001 : lineCount;
	wire logic lastLine = (remaining == 13'h0001);
	wire logic [15:0] engineStatus = {busy, lastClipped, 1'b0, remaining};

	wire logic [31:0] readWord =
		(addr == OFS_SETUP_PAT) ? {3'h0, setupPat, 6'h00} :
		(addr == OFS_DEST) ? {3'h0, destAddr} :
		(addr == OFS_SRC_PITCH) ? {engineStatus, srcPitch} :
		(addr == OFS_SRC) ? {3'h0, srcAddr} :
		(addr == OFS_ROP) ? ropCtrl :
		(addr == OFS_CMD) ? {24'h000000, cmdCfg} :
		(addr == OFS_PAT) ? {3'h0, patAddr, 6'h00} :
		(addr == OFS_CLIP_TOP) ? {3'h0, clipTop} :
		(addr == OFS_CLIP_BOT) ? {3'h0, clipBot} :
		(addr == OFS_LINES) ? {19'h00000, lineCount} :
		RST_WORD;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (startHit) begin
					next_state = needFetch ? ST_PAT : ST_ISSUE;
				end
			end
			ST_PAT: begin
				if (patAck) begin
					next_state = ST_ISSUE;
				end
			end
			ST_ISSUE: next_state = ST_LINE;
			ST_LINE: begin
				if (lineAck) begin
					next_state = ST_STEP;
				end
			end
			ST_STEP: next_state = lastLine ? ST_IDLE : ST_ISSUE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_IDLE;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			busy <= (next_state != ST_IDLE);
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			setupPat <= RST_WORD[ADDR_MSB:PAT_LSB];
			patAddr <= RST_WORD[ADDR_MSB:PAT_LSB];
			srcPitch <= RST_WORD[15:0];
			ropCtrl <= RST_WORD;
			cmdCfg <= RST_WORD[7:0];
			clipTop <= RST_WORD[ADDR_MSB:0];
			clipBot <= RST_WORD[ADDR_MSB:0];
			lineCount <= RST_LINES;
		end else if (wrOk) begin
			case (addr)
				OFS_SETUP_PAT: setupPat <= wrData[ADDR_MSB:PAT_LSB];
				OFS_SRC_PITCH: srcPitch <= wrData[15:0];
				OFS_ROP: ropCtrl <= wrData;
				OFS_CMD: cmdCfg <= wrData[7:0];
				OFS_PAT: patAddr <= wrData[ADDR_MSB:PAT_LSB];
				OFS_CLIP_TOP: clipTop <= wrData[ADDR_MSB:0];
				OFS_CLIP_BOT: clipBot <= wrData[ADDR_MSB:0];
				OFS_LINES: lineCount <= wrData[12:0];
				default: lineCount <= lineCount;
			endcase
		end
	end

	// ----------------------------------------
	// Working addresses
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			destAddr <= RST_WORD[ADDR_MSB:0];
			srcAddr <= RST_WORD[ADDR_MSB:0];
		end else if (wrOk && addr == OFS_DEST) begin
			destAddr <= wrData[ADDR_MSB:0];
		end else if (wrOk && addr == OFS_SRC) begin
			srcAddr <= wrData[ADDR_MSB:0];
		end else if (state == ST_STEP && !lastLine) begin
			destAddr <= destAddr + dstStep;
			if (colourSrc) begin
				srcAddr <= srcAddr + srcStep;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			remaining <= RST_LINES;
		end else if (startHit) begin
			remaining <= startLines;
		end else if (state == ST_STEP) begin
			remaining <= remaining - 13'h0001;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdData <= RST_WORD;
			patReq <= 1'b0;
			patCmd <= '0;
			patUseBg <= 1'b0;
			ropCode <= RST_WORD[7:0];
		end else begin
			rdData <= rdEn ? readWord : RST_WORD;
			patReq <= startHit && needFetch;
			if (startHit) begin
				patCmd.addr <= patBase;
				patCmd.bytes <= patBytes(depth);
				// Solid select means nothing for colour patterns
				patUseBg <= monoPat && solidSel;
				ropCode <= ropCtrl[ROP_CODE_LSB +: 8];
			end
		end
	end

	// Line command stays stable until the next issue so the memory side may sample late
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lineReq <= 1'b0;
			lineCmd <= '0;
			lastClipped <= 1'b0;
		end else begin
			lineReq <= (state == ST_ISSUE);
			if (state == ST_ISSUE) begin
				lineCmd.dst <= destAddr;
				lineCmd.src <= srcAddr;
				lineCmd.firstByte <= srcAddr[2:0];
				lineCmd.writeEn <= lineWrite;
				lastClipped <= !lineWrite;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_dest_start: assert property (@(posedge clk_sys) disable iff (rst)
		startHit |=> busy ##0 (ropCode == $past(ropCtrl[23:16])))
		else $error("Destination write did not start the engine");

	a_setup_low_zero: assert property (@(posedge clk_sys) disable iff (rst)
		rdEn && addr == OFS_SETUP_PAT |=> rdData[5:0] == 6'h00 && rdData[28:6] == $past(setupPat))
		else $error("Setup pattern read back wrong");

	a_addr_top_zero: assert property (@(posedge clk_sys) disable iff (rst)
		rdEn && (addr == OFS_DEST || addr == OFS_SRC) |=> rdData[31:29] == 3'h0)
		else $error("Address top bits not zero");

	a_pat_source: assert property (@(posedge clk_sys) disable iff (rst)
		patReq |-> patCmd.addr == ((cmdType == CMD_LINE) ? {setupPat, 6'h00} : {patAddr, 6'h00}))
		else $error("Wrong pattern address used");

	a_pat_size: assert property (@(posedge clk_sys) disable iff (rst)
		patReq |-> patCmd.bytes == patBytes(depth) && !monoPat)
		else $error("Pattern fetch size or kind wrong");

	a_solid_bg: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(busy) |-> patUseBg == (monoPat && solidSel) && !(patReq && monoPat))
		else $error("Solid pattern select misapplied");

	a_src_step: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_STEP && !lastLine && colourSrc |=> srcAddr == $past(srcAddr) + $past(srcStep))
		else $error("Source address did not advance by pitch");

	a_clip_gate: assert property (@(posedge clk_sys) disable iff (rst)
		lineReq |-> lineCmd.writeEn == (!(clipEn && clipCmd) ||
			(lineCmd.dst >= clipTop && lineCmd.dst <= clipBot)))
		else $error("Clip decision wrong");

	a_line_issue: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_LINE && lineAck |=> state == ST_STEP ##1 (busy == !$past(lastLine)))
		else $error("Line sequencing wrong");

	a_status_read: assert property (@(posedge clk_sys) disable iff (rst)
		rdEn && addr == OFS_SRC_PITCH |=>
			rdData == {$past(busy), $past(lastClipped), 1'b0, $past(remaining), $past(srcPitch)})
		else $error("Pitch register status read wrong");

	a_dest_load: assert property (@(posedge clk_sys) disable iff (rst)
		destHit |=> destAddr == $past(wrData[ADDR_MSB:0]) && busy == ($past(cmdType) != CMD_SETUP))
		else $error("Destination write handled wrong");

	a_line_launch: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_ISSUE |=> lineReq && lineCmd.dst == $past(destAddr) && lineCmd.src == $past(srcAddr))
		else $error("Line command addresses wrong");

	a_first_byte: assert property (@(posedge clk_sys) disable iff (rst)
		lineReq |-> lineCmd.firstByte == lineCmd.src[2:0])
		else $error("First byte position wrong");

	a_dst_step: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_STEP && !lastLine && !(coordBlit && tiledDst) |=>
			destAddr == $past(destAddr) + {{13{$past(ropCtrl[15])}}, $past(ropCtrl[15:0])})
		else $error("Destination address did not advance by pitch");

	a_last_hold: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_STEP && lastLine |=> $stable(destAddr) && $stable(srcAddr) && !busy)
		else $error("Addresses moved after last line");

	a_src_hold: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_STEP && !colourSrc |=> $stable(srcAddr))
		else $error("Source address moved without colour source");

	a_pitch_dword: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_STEP && !lastLine && colourSrc && coordBlit && tiledSrc |=>
			srcAddr == $past(srcAddr) + {{11{$past(srcPitch[15])}}, $past(srcPitch), 2'b00})
		else $error("Tiled source pitch not in doublewords");

	a_pitch_bytes: assert property (@(posedge clk_sys) disable iff (rst)
		state == ST_STEP && !lastLine && colourSrc && !(coordBlit && tiledSrc) |=>
			srcAddr == $past(srcAddr) + {{13{$past(srcPitch[15])}}, $past(srcPitch)})
		else $error("Linear source pitch not in bytes");

	a_mono_skip: assert property (@(posedge clk_sys) disable iff (rst)
		startHit && monoPat |=> !patReq && state == ST_ISSUE)
		else $error("Mono pattern was fetched");

	a_colour_fetch: assert property (@(posedge clk_sys) disable iff (rst)
		startHit && !monoPat && cmdType != CMD_PIXEL |=> patReq && state == ST_PAT)
		else $error("Colour pattern not fetched");

	a_clip_off: assert property (@(posedge clk_sys) disable iff (rst)
		lineReq && !clipEn |-> lineCmd.writeEn)
		else $error("Line dropped with clipping off");

	a_colour_no_bg: assert property (@(posedge clk_sys) disable iff (rst)
		busy && !monoPat |-> !patUseBg)
		else $error("Solid select applied to colour pattern");

endmodule // bew_engine_regs

// ### hdl/bew_pkg.sv
package bew_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_SETUP_PAT = 8'h00;
	localparam logic [7:0] OFS_DEST = 8'h04;
	localparam logic [7:0] OFS_SRC_PITCH = 8'h08;
	localparam logic [7:0] OFS_SRC = 8'h0C;
	localparam logic [7:0] OFS_ROP = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_PAT = 8'h18;
	localparam logic [7:0] OFS_CLIP_TOP = 8'h1C;
	localparam logic [7:0] OFS_CLIP_BOT = 8'h20;
	localparam logic [7:0] OFS_LINES = 8'h24;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ADDR_MSB = 28;
	localparam int PAT_LSB = 6;
	localparam int ROP_SOLID_BIT = 31;
	localparam int ROP_CLIP_BIT = 30;
	localparam int ROP_CODE_LSB = 16;
	localparam int ROP_DEPTH_LSB = 24;
	localparam int CMD_MONO_PAT_BIT = 4;
	localparam int CMD_COORD_BIT = 5;
	localparam int CMD_TILED_SRC_BIT = 6;
	localparam int CMD_TILED_DST_BIT = 7;

	// ----------------------------------------
	// Commands, sizes, reset values
	// ----------------------------------------
	localparam logic [2:0] CMD_SETUP = 3'h0;
	localparam logic [2:0] CMD_LINE = 3'h1;
	localparam logic [2:0] CMD_PIXEL = 3'h2;
	localparam logic [2:0] CMD_GLYPH = 3'h3;
	localparam logic [2:0] CMD_FILL = 3'h4;
	localparam logic [2:0] CMD_COPY = 3'h5;
	localparam logic [8:0] PAT_BYTES_8 = 9'h040;
	localparam logic [8:0] PAT_BYTES_16 = 9'h080;
	localparam logic [8:0] PAT_BYTES_32 = 9'h100;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [12:0] RST_LINES = 13'h0000;

	typedef struct packed {
		logic [28:0] addr;
		logic [8:0] bytes;
	} bew_pat_t;

	typedef struct packed {
		logic [28:0] dst;
		logic [28:0] src;
		logic [2:0] firstByte;
		logic writeEn;
	} bew_line_t;

endpackage

// ### tb/bew_far_model.sv
`timescale 1ns/1ps
module bew_far_model
	import bew_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] delay,
	input wire logic patReq,
	input wire logic lineReq,
	input wire bew_line_t lineCmd,
	output logic patAck,
	output logic lineAck,
	output logic [3:0] patCount,
	output logic [3:0] lineCount,
	output bew_line_t lineLog [16]
);
	logic [3:0] patWait;
	logic [3:0] lineWait;
	logic patPend;
	logic linePend;
	// ----------------------------------------
	// Memory side, answers after a stall
	// ----------------------------------------
	// Stall set by the bench, so slow memory is also seen
	always_ff @(posedge clk_sys) begin
		patAck <= 1'b0;
		lineAck <= 1'b0;
		if (rst) begin
			patPend <= 1'b0;
			linePend <= 1'b0;
			patCount <= 4'h0;
			lineCount <= 4'h0;
		end else begin
			if (patReq) begin
				patPend <= 1'b1;
				patWait <= delay;
				patCount <= patCount + 4'h1;
			end else if (patPend && patWait == 4'h0) begin
				patPend <= 1'b0;
				patAck <= 1'b1;
			end else if (patPend) begin
				patWait <= patWait - 4'h1;
			end
			if (lineReq) begin
				linePend <= 1'b1;
				lineWait <= delay;
				lineLog[lineCount] <= lineCmd;
				lineCount <= lineCount + 4'h1;
			end else if (linePend && lineWait == 4'h0) begin
				linePend <= 1'b0;
				lineAck <= 1'b1;
			end else if (linePend) begin
				lineWait <= lineWait - 4'h1;
			end
		end
	end
endmodule // bew_far_model

// ### tb/blit_engine_working_registers_test.sv
`timescale 1ns/1ps
module blit_engine_working_registers_test
	import bew_pkg::*;
;
	logic clk_sys, rst, wrEn, rdEn, patAck, lineAck, patReq, lineReq, patUseBg, busy;
	logic [7:0] addr, ropCode;
	logic [31:0] wrData, rdData;
	logic [3:0] delay, patCount, lineCount, base, pc;
	bew_pat_t patCmd;
	bew_line_t lineCmd;
	bew_line_t lineLog [16];
	int failures, samples_checked;

	bew_engine_regs i_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData(rdData), .patAck(patAck), .lineAck(lineAck), .patReq(patReq), .patCmd(patCmd),
		.lineReq(lineReq), .lineCmd(lineCmd), .patUseBg(patUseBg), .ropCode(ropCode), .busy(busy));
	bew_far_model i_far (.clk_sys(clk_sys), .rst(rst), .delay(delay), .patReq(patReq), .lineReq(lineReq),
		.lineCmd(lineCmd), .patAck(patAck), .lineAck(lineAck), .patCount(patCount), .lineCount(lineCount),
		.lineLog(lineLog));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clk_sys);
		wrEn <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk_sys);
		rdEn <= 1'b0;
		#1;
		chk({32'h0, rdData}, {32'h0, exp});
	endtask
	task automatic go(input logic [7:0] cfg, input logic [31:0] raster_operation_code, input logic [12:0] n, input logic [31:0] d);
		wr(OFS_CMD, {24'h0, cfg});
		wr(OFS_ROP, raster_operation_code);
		wr(OFS_LINES, {19'h0, n});
		base = lineCount;
		pc = patCount;
		wr(OFS_DEST, d);
		chk({63'h0, busy}, 64'h1);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk({63'h0, busy}, 64'h0);
	endtask
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog, tests
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Whole run is under two hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		wrEn = 1'b0;
		rdEn = 1'b0;
		addr = 8'h00;
		wrData = 32'h0;
		delay = 4'h0;
		failures = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) rd(8'(4 * i), RST_WORD);
		wr(OFS_SETUP_PAT, 32'hFFFF_FFFF);
		rd(OFS_SETUP_PAT, 32'h1FFF_FFC0);
		wr(OFS_DEST, 32'hFFFF_FFFF);
		chk({63'h0, busy}, 64'h0);
		rd(OFS_DEST, 32'h1FFF_FFFF);
		wr(OFS_SRC, 32'hFFFF_FFFF);
		rd(OFS_SRC, 32'h1FFF_FFFF);
		wr(OFS_SRC_PITCH, 32'hFFFF_FFFF);
		rd(OFS_SRC_PITCH, 32'h0000_FFFF);
		wr(OFS_ROP, 32'hA5C3_1234);
		rd(OFS_ROP, 32'hA5C3_1234);
		rd(8'h3C, 32'h0);
		$display("test registers done");
		// Colour copy, solid select set but ignored, slow memory
		delay <= 4'h3;
		wr(OFS_PAT, 32'h0000_0100);
		wr(OFS_SRC_PITCH, 32'h0000_FFF0);
		wr(OFS_SRC, 32'h0000_1003);
		go(8'h05, 32'h83CC_0100, 13'h2, 32'h0000_2000);
		chk({56'h0, ropCode}, 64'hCC);
		chk({63'h0, patUseBg}, 64'h0);
		rd(OFS_SRC_PITCH, 32'h8002_FFF0);
		wait_idle();
		chk({60'h0, patCount}, {60'h0, pc + 4'h1});
		chk({26'h0, patCmd}, {26'h0, 29'h100, 9'h100});
		chk({2'h0, lineLog[base]}, {2'h0, 29'h2000, 29'h1003, 3'h3, 1'b1});
		chk({2'h0, lineLog[base + 4'h1]}, {2'h0, 29'h2100, 29'h0FF3, 3'h3, 1'b1});
		chk({60'h0, lineCount}, {60'h0, base + 4'h2});
		rd(OFS_DEST, 32'h0000_2100);
		// Tiled coordinate copy, pitch in doublewords
		delay <= 4'h0;
		wr(OFS_SRC_PITCH, 32'h0000_0004);
		wr(OFS_SRC, 32'h0000_1000);
		go(8'h65, 32'h0000_0010, 13'h2, 32'h0000_4000);
		wait_idle();
		chk({26'h0, patCmd}, {26'h0, 29'h100, 9'h040});
		chk({2'h0, lineLog[base + 4'h1]}, {2'h0, 29'h4010, 29'h1010, 3'h0, 1'b1});
		$display("test copy done");
		// Line draw uses the setup pattern, clipped out
		wr(OFS_SETUP_PAT, 32'h0000_0080);
		wr(OFS_CLIP_TOP, 32'h0000_3000);
		wr(OFS_CLIP_BOT, 32'h0000_3FFF);
		go(8'h01, 32'h4100_0000, 13'h0, 32'h0000_5000);
		wait_idle();
		chk({26'h0, patCmd}, {26'h0, 29'h80, 9'h080});
		chk({63'h0, lineLog[base].writeEn}, 64'h0);
		rd(OFS_SRC_PITCH, 32'h4000_0004);
		// Mono pixel with solid select, inside clip
		go(8'h12, 32'hC000_0000, 13'h0, 32'h0000_3800);
		chk({63'h0, patUseBg}, 64'h1);
		wait_idle();
		chk({60'h0, patCount}, {60'h0, pc});
		chk({63'h0, lineLog[base].writeEn}, 64'h1);
		// Mono glyph, solid select clear, zero line count
		go(8'h13, 32'h4000_0000, 13'h0, 32'h0000_2FFF);
		chk({63'h0, patUseBg}, 64'h0);
		wait_idle();
		chk({60'h0, lineCount}, {60'h0, base + 4'h1});
		chk({63'h0, lineLog[base].writeEn}, 64'h0);
		// Mono fill, tiled coordinate destination, pitch in doublewords
		go(8'hB4, 32'h0000_0020, 13'h2, 32'h0000_6000);
		wait_idle();
		chk({60'h0, patCount}, {60'h0, pc});
		chk({2'h0, lineLog[base + 4'h1]}, {2'h0, 29'h6080, 29'h1010, 3'h0, 1'b1});
		$display("test draw done");
		final_report();
	end
endmodule // blit_engine_working_registers_test
